// ===== tb/timer_transfer_instr_exec_tb_top.sv
// Self-checking bench for the timer-transfer execution block
`timescale 1ns/1ps
module timer_transfer_instr_exec_tb_top;
  typedef struct packed {
    tte_pkg::tte_tmr_wr_t t;
    tte_pkg::tte_reg_wr_t r;
    logic                 cw;
    logic                 sk;
  } tte_note_t;
  localparam logic [9:0] OPS [6] = '{tte_pkg::OP_LOAD_T1, tte_pkg::OP_LOAD_T2,
    tte_pkg::OP_LOAD_R2H, tte_pkg::OP_COPY_R2L, tte_pkg::OP_MOVE_AUX, tte_pkg::OP_READ_T1};
  logic clk, rst, instr_valid;
  logic [9:0] instr;
  logic [3:0] acc, aux;
  logic [7:0] timer_one, timer_two, r2l;
  tte_pkg::tte_tmr_wr_t tmr_wr;
  tte_pkg::tte_reg_wr_t reg_wr;
  logic carry_we, skip_next;
  int fail_count, cmp_count, cycles, seed;
  tte_note_t note_q[$];
  tte_note_t exp_n, seen_n;

  tte_exec tte_exec_inst (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .acc(acc), .aux(aux), .timer_one(timer_one), .timer_two_reload_low(r2l),
    .tmr_wr(tmr_wr), .reg_wr(reg_wr), .carry_we(carry_we), .skip_next(skip_next));
  tte_tmr_model tte_tmr_model_inst (.clk(clk), .rst(rst), .tmr_wr(tmr_wr),
    .timer_one(timer_one), .timer_two(timer_two), .timer_two_reload_low(r2l));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Expected outputs; carry and skip stay zero for every instruction
  function automatic tte_note_t expect_of(logic [9:0] w, logic v);
    tte_note_t n;
    logic [7:0] b;
    n = '0;
    b = {aux, acc};
    if (v) begin
      case (w)
        tte_pkg::OP_LOAD_T1:   n.t = {5'b11000, b, 8'h00, b};
        tte_pkg::OP_LOAD_T2:   n.t = {5'b00110, 8'h00, b, b};
        tte_pkg::OP_LOAD_R2H:  n.t = {5'b00001, 16'h0000, b};
        tte_pkg::OP_COPY_R2L:  n.t = {5'b00100, 8'h00, r2l, 8'h00};
        tte_pkg::OP_MOVE_AUX:  n.r = {2'b10, aux, 4'h0};
        tte_pkg::OP_READ_T1:   n.r = {2'b11, timer_one[3:0], timer_one[7:4]};
        default:               n = '0;
      endcase
    end
    return n;
  endfunction

  // Data fields with no strobe are don't-care, except on refused words
  function automatic tte_note_t keep(tte_note_t s, tte_note_t e);
    tte_note_t r;
    r = s;
    if (e === '0) return r;
    if (!e.t.timer_one_we) r.t.timer_one_d = e.t.timer_one_d;
    if (!e.t.timer_two_we) r.t.timer_two_d = e.t.timer_two_d;
    if (!e.t.timer_one_reload_we && !e.t.timer_two_reload_low_we &&
        !e.t.timer_two_reload_high_we) r.t.reload_d = e.t.reload_d;
    if (!e.r.acc_we) r.r.acc_d = e.r.acc_d;
    if (!e.r.aux_we) r.r.aux_d = e.r.aux_d;
    return r;
  endfunction

  task automatic check(tte_note_t seen, tte_note_t exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic issue(logic [9:0] w, logic v);
    @(negedge clk);
    instr = w;
    instr_valid = v;
    acc = 4'($random(seed));
    aux = 4'($random(seed));
    note_q.push_back(expect_of(w, v));
  endtask

  task automatic complete_run();
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: results settle just after the taking edge
  always @(posedge clk) begin
    #1;
    if (note_q.size() > 0) begin
      exp_n = note_q.pop_front();
      seen_n = {tmr_wr, reg_wr, carry_we, skip_next};
      check(keep(seen_n, exp_n), exp_n);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    seed = 38;
    rst = 1'b1;
    instr = '0;
    instr_valid = 1'b0;
    acc = '0;
    aux = '0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int i = 0; i < 6; i++) issue(OPS[i], 1'b1);
    for (int i = 0; i < 6; i++) begin
      issue(OPS[i] ^ (10'h001 << ({$random(seed)} % 10)), 1'b1);
      issue(OPS[i], 1'b0);
    end
    repeat (400) issue(OPS[{$random(seed)} % 6], ({$random(seed)} % 8) != 0);
    // Mid-run reset: outputs clear under reset and after release with no word
    @(negedge clk);
    rst = 1'b1;
    note_q.push_back('0);
    @(negedge clk);
    rst = 1'b0;
    instr_valid = 1'b0;
    note_q.push_back('0);
    for (int i = 0; i < 6; i++) issue(OPS[i], 1'b1);
    repeat (3) issue(10'h000, 1'b0);
    @(posedge clk);
    #2;
    complete_run();
  end
endmodule

// ===== tb/tte_tmr_model.sv
// Timer unit model that applies the block's timer one, timer two and low reload write strobes
`timescale 1ns/1ps
module tte_tmr_model (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Writes from the block
  input  wire tte_pkg::tte_tmr_wr_t         tmr_wr,
  // Timer state; timer_one and the low reload are seen by the block
  output logic [tte_pkg::BYTE_W-1:0]        timer_one,
  output logic [tte_pkg::BYTE_W-1:0]        timer_two,
  output logic [tte_pkg::BYTE_W-1:0]        timer_two_reload_low
);
  // ==========================================================================
  // Strobes land at the edge after they appear; nonzero reset exposes stale data
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_one <= 8'h96;
      timer_two <= 8'h3c;
      timer_two_reload_low <= 8'hc3;
    end else begin
      if (tmr_wr.timer_one_we) timer_one <= tmr_wr.timer_one_d;
      if (tmr_wr.timer_two_we) timer_two <= tmr_wr.timer_two_d;
      if (tmr_wr.timer_two_reload_low_we) timer_two_reload_low <= tmr_wr.reload_d;
    end
  end
endmodule

// ===== verilog/tte_decode.sv
// Exact-match opcode decoder for the timer-transfer instructions
`timescale 1ns/1ps
module tte_decode (
  // Instruction
  input  wire logic [tte_pkg::INSTR_W-1:0] instr,
  input  wire logic                        instr_valid,
  // Decoded kind
  output tte_pkg::tte_op_t                 op
);
  // ==========================================================================
  // Whole word compared; no don't-care bits
  always_comb begin
    op = tte_pkg::OPK_NONE;
    if (!instr_valid) begin
      op = tte_pkg::OPK_NONE;
    end else if (instr == tte_pkg::OP_LOAD_T1) begin
      op = tte_pkg::OPK_LOAD_T1;
    end else if (instr == tte_pkg::OP_LOAD_T2) begin
      op = tte_pkg::OPK_LOAD_T2;
    end else if (instr == tte_pkg::OP_LOAD_R2H) begin
      op = tte_pkg::OPK_LOAD_R2H;
    end else if (instr == tte_pkg::OP_COPY_R2L) begin
      op = tte_pkg::OPK_COPY_R2L;
    end else if (instr == tte_pkg::OP_MOVE_AUX) begin
      op = tte_pkg::OPK_MOVE_AUX;
    end else if (instr == tte_pkg::OP_READ_T1) begin
      op = tte_pkg::OPK_READ_T1;
    end
  end
endmodule

// ===== verilog/tte_exec.sv
// Execution of the timer-transfer and register-move instructions
`timescale 1ns/1ps
module tte_exec (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Instruction from the decoder stage
  input  wire logic [tte_pkg::INSTR_W-1:0]  instr,
  input  wire logic                         instr_valid,
  // Current core and timer state
  input  wire logic [tte_pkg::NIB_W-1:0]    acc,
  input  wire logic [tte_pkg::NIB_W-1:0]    aux,
  input  wire logic [tte_pkg::BYTE_W-1:0]   timer_one,
  input  wire logic [tte_pkg::BYTE_W-1:0]   timer_two_reload_low,
  // Writes to the timer unit and register file
  output tte_pkg::tte_tmr_wr_t              tmr_wr,
  output tte_pkg::tte_reg_wr_t              reg_wr,
  // Flow control results
  output logic                              carry_we,
  output logic                              skip_next
);
  tte_pkg::tte_op_t                op;
  logic [tte_pkg::BYTE_W-1:0]      pair;
  tte_pkg::tte_tmr_wr_t            tmr_wr_r;
  tte_pkg::tte_reg_wr_t            reg_wr_r;
  tte_pkg::tte_tmr_wr_t            tmr_wr_nxt;
  tte_pkg::tte_reg_wr_t            reg_wr_nxt;

  // Pairing puts two nibbles in one timer byte; other widths cannot be served
  if (tte_pkg::BYTE_W != 2 * tte_pkg::NIB_W) begin : g_width_check
    $error("timer byte must hold exactly two nibbles");
  end

  tte_decode tte_decode_inst (
    .instr       (instr),
    .instr_valid (instr_valid),
    .op          (op)
  );

  // ==========================================================================
  // Next writes
  assign pair = {aux, acc};

  always_comb begin
    tmr_wr_nxt = '0;
    reg_wr_nxt = '0;
    case (op)
      tte_pkg::OPK_LOAD_T1: begin
        tmr_wr_nxt.timer_one_we        = 1'b1;
        tmr_wr_nxt.timer_one_reload_we = 1'b1;
        tmr_wr_nxt.timer_one_d         = pair;
        tmr_wr_nxt.reload_d            = pair;
      end
      tte_pkg::OPK_LOAD_T2: begin
        tmr_wr_nxt.timer_two_we            = 1'b1;
        tmr_wr_nxt.timer_two_reload_low_we = 1'b1;
        tmr_wr_nxt.timer_two_d             = pair;
        tmr_wr_nxt.reload_d                = pair;
      end
      tte_pkg::OPK_LOAD_R2H: begin
        tmr_wr_nxt.timer_two_reload_high_we = 1'b1;
        tmr_wr_nxt.reload_d                 = pair;
      end
      tte_pkg::OPK_COPY_R2L: begin
        tmr_wr_nxt.timer_two_we = 1'b1;
        tmr_wr_nxt.timer_two_d  = timer_two_reload_low;
      end
      tte_pkg::OPK_MOVE_AUX: begin
        reg_wr_nxt.acc_we = 1'b1;
        reg_wr_nxt.acc_d  = aux;
      end
      tte_pkg::OPK_READ_T1: begin
        reg_wr_nxt.aux_we = 1'b1;
        reg_wr_nxt.aux_d  = timer_one[tte_pkg::BYTE_W-1:tte_pkg::NIB_W];
        reg_wr_nxt.acc_we = 1'b1;
        reg_wr_nxt.acc_d  = timer_one[tte_pkg::NIB_W-1:0];
      end
      default: begin
        tmr_wr_nxt = '0;
        reg_wr_nxt = '0;
      end
    endcase
  end

  // ==========================================================================
  // Registered write strobes, applied by the owners at the next edge
  // Registering costs one cycle of latency but keeps outputs glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_wr_r <= '0;
    end else begin
      tmr_wr_r <= tmr_wr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_wr_r <= '0;
    end else begin
      reg_wr_r <= reg_wr_nxt;
    end
  end

  // None of these instructions touch carry or skip
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_we  <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      carry_we  <= 1'b0;
      skip_next <= 1'b0;
    end
  end

  assign tmr_wr = tmr_wr_r;
  assign reg_wr = reg_wr_r;

  // ==========================================================================
  // Checks
  a_t1_load_data: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_LOAD_T1) |=>
      (tmr_wr.timer_one_we && tmr_wr.timer_one_reload_we &&
       tmr_wr.timer_one_d == {$past(aux), $past(acc)} &&
       tmr_wr.reload_d == {$past(aux), $past(acc)}))
    else $error("timer one load wrong");

  a_t2_load_data: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_LOAD_T2) |=>
      (tmr_wr.timer_two_we && tmr_wr.timer_two_reload_low_we &&
       !tmr_wr.timer_one_we && tmr_wr.timer_two_d == {$past(aux), $past(acc)} &&
       tmr_wr.reload_d == {$past(aux), $past(acc)}))
    else $error("timer two load wrong");

  a_r2h_load_data: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_LOAD_R2H) |=>
      (tmr_wr.timer_two_reload_high_we && !tmr_wr.timer_two_we &&
       tmr_wr.reload_d == {$past(aux), $past(acc)}))
    else $error("high reload load wrong");

  a_r2l_copy_data: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_COPY_R2L) |=>
      (tmr_wr.timer_two_we && tmr_wr.timer_two_d == $past(timer_two_reload_low)))
    else $error("reload copy wrong");

  a_move_aux_acc: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_MOVE_AUX) |=>
      (reg_wr.acc_we && !reg_wr.aux_we && reg_wr.acc_d == $past(aux)))
    else $error("aux move wrong");

  a_t1_read_data: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_READ_T1) |=>
      (reg_wr.acc_we && reg_wr.aux_we &&
       {reg_wr.aux_d, reg_wr.acc_d} == $past(timer_one)))
    else $error("timer one read wrong");

  a_no_carry_skip: assert property (@(posedge clk) disable iff (rst)
    ##1 (!carry_we && !skip_next))
    else $error("carry or skip disturbed");

  a_exact_match: assert property (@(posedge clk) disable iff (rst)
    (!instr_valid || (instr != tte_pkg::OP_LOAD_T1 && instr != tte_pkg::OP_LOAD_T2 &&
      instr != tte_pkg::OP_LOAD_R2H && instr != tte_pkg::OP_COPY_R2L &&
      instr != tte_pkg::OP_MOVE_AUX && instr != tte_pkg::OP_READ_T1)) |=>
      (tmr_wr == '0 && reg_wr == '0))
    else $error("write on unmatched word");

  a_idle_no_write: assert property (@(posedge clk) disable iff (rst)
    !instr_valid |=>
      (tmr_wr == '0 && reg_wr == '0))
    else $error("write without a valid word");

  // ==========================================================================
  // Side effects: each kind raises only its own strobes, a stray one would
  // silently corrupt a timer or register that the program still relies on
  a_t1_load_only: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_LOAD_T1) |=>
      (!tmr_wr.timer_two_we && !tmr_wr.timer_two_reload_low_we &&
       !tmr_wr.timer_two_reload_high_we &&
       !reg_wr.acc_we && !reg_wr.aux_we))
    else $error("timer one load touched other state");

  a_t2_load_only: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_LOAD_T2) |=>
      (!tmr_wr.timer_one_reload_we &&
       !tmr_wr.timer_two_reload_high_we &&
       !reg_wr.acc_we && !reg_wr.aux_we))
    else $error("timer two load touched other state");

  a_r2h_load_only: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_LOAD_R2H) |=>
      (!tmr_wr.timer_one_we && !tmr_wr.timer_one_reload_we &&
       !tmr_wr.timer_two_reload_low_we &&
       !reg_wr.acc_we && !reg_wr.aux_we))
    else $error("high reload load touched other state");

  a_r2l_copy_only: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_COPY_R2L) |=>
      (!tmr_wr.timer_one_we && !tmr_wr.timer_one_reload_we &&
       !tmr_wr.timer_two_reload_low_we &&
       !tmr_wr.timer_two_reload_high_we &&
       !reg_wr.acc_we && !reg_wr.aux_we))
    else $error("reload copy touched other state");

  a_move_aux_only: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_MOVE_AUX) |=>
      (!tmr_wr.timer_one_we && !tmr_wr.timer_one_reload_we &&
       !tmr_wr.timer_two_we &&
       !tmr_wr.timer_two_reload_low_we &&
       !tmr_wr.timer_two_reload_high_we))
    else $error("aux move touched timer state");

  a_t1_read_only: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr == tte_pkg::OP_READ_T1) |=>
      (!tmr_wr.timer_one_we && !tmr_wr.timer_one_reload_we &&
       !tmr_wr.timer_two_we &&
       !tmr_wr.timer_two_reload_low_we &&
       !tmr_wr.timer_two_reload_high_we))
    else $error("timer one read touched timer state");

  // ==========================================================================
  // Reset
  a_reset_clear: assert property (@(posedge clk)
    rst |=> (tmr_wr == '0 && reg_wr == '0 && !carry_we && !skip_next))
    else $error("outputs not cleared by reset");

endmodule

// ===== verilog/tte_pkg.sv
// Package of opcodes and carriers for the timer-transfer execution block
// ==========================================================================
// Function
// - Timer-1 load writes aux to high nibble, acc to low, of timer 1 and reload.
// - Timer-2 load writes aux/acc nibbles into timer 2 and low reload; one cycle.
// - High-reload load writes aux/acc nibbles into timer-2 high reload; carry kept.
// - Reload copy loads all eight timer-2 bits from the low reload register.
// - Timer-1 read puts timer-1 high nibble in aux, low nibble in acc.
package tte_pkg;

  localparam int INSTR_W = 10;
  localparam int NIB_W   = 4;
  localparam int BYTE_W  = 8;

  // ==========================================================================
  // Opcodes
  localparam logic [INSTR_W-1:0] OP_LOAD_T1    = 10'h230;
  localparam logic [INSTR_W-1:0] OP_LOAD_T2    = 10'h231;
  localparam logic [INSTR_W-1:0] OP_LOAD_R2H   = 10'h294;
  localparam logic [INSTR_W-1:0] OP_COPY_R2L   = 10'h295;
  localparam logic [INSTR_W-1:0] OP_MOVE_AUX   = 10'h01e;
  localparam logic [INSTR_W-1:0] OP_READ_T1    = 10'h270;

  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [NIB_W-1:0]  NIB_RST  = 4'h0;

  // ==========================================================================
  // Decoded operation
  typedef enum logic [2:0] {
    OPK_NONE     = 3'b000,
    OPK_LOAD_T1  = 3'b001,
    OPK_LOAD_T2  = 3'b010,
    OPK_LOAD_R2H = 3'b011,
    OPK_COPY_R2L = 3'b100,
    OPK_MOVE_AUX = 3'b101,
    OPK_READ_T1  = 3'b110
  } tte_op_t;

  // Write strobes and data toward the timer unit
  typedef struct packed {
    logic              timer_one_we;
    logic              timer_one_reload_we;
    logic              timer_two_we;
    logic              timer_two_reload_low_we;
    logic              timer_two_reload_high_we;
    logic [BYTE_W-1:0] timer_one_d;
    logic [BYTE_W-1:0] timer_two_d;
    logic [BYTE_W-1:0] reload_d;
  } tte_tmr_wr_t;

  // Write strobes and data toward the register file
  typedef struct packed {
    logic             acc_we;
    logic             aux_we;
    logic [NIB_W-1:0] acc_d;
    logic [NIB_W-1:0] aux_d;
  } tte_reg_wr_t;

endpackage
